/* hdl/apem_pkg.sv */
// Behaviour
// (RQ1) Measure each master clock over 32-cycle windows; count readable by software.
// (RQ2) Set clock-fail flag whenever measurement lies outside programmed bounds.
// (RQ3) Mute output goes to programmed level on selected error or external request.
// (RQ4) Interrupt requests raised from software-selected error sources.
// (RQ5) Burst mode: sync before current slot completes is unexpected.
// (RQ6) TDM mode: sync only on the exact bit clock before slot 0.
// (RQ7) Sync during current frame is early; frame sync delay overlap is not.
// (RQ8) Early sync: flag, finish current frame, resync on next sync after it.
// (RQ9) Gap after frame end: flag at once, resync on next sync.
// (RQ10) Late sync detection same in both modes; burst late interrupt left off.
// (RQ11) Underrun flag for transmitters when buffer unwritten since previous transfer.
// (RQ12) Underrun checked once per slot; flag sticky until software writes one.
// (RQ13) Biphase mode underrun sends a pair of biphase zeros, four bit times.
// (RQ14) TDM underrun sends continuous zeros; recovery by full port reinitialisation; here clearing the underrun flag ends the zeros.
// (RQ15) Receive transfer into unread buffer sets overrun, overwrites, keeps going.
// (RQ16) Overrun checked once per slot; flag sticky until software writes one.
// (RQ17) Too many data port writes per transmit event sets transmit DMA error.
// (RQ18) Too many data port reads per receive event sets receive DMA error.
// (RQ19) Host writes one word per transmitter per event; reinitialises after errors.
// (RQ20) Clock-fail reported after start-up until one full window is measured.
// (RQ21) Software programs bounds, clears flag, waits, checks before enabling uses.
// (RQ22) Receive side offers interrupt and mute only, no automatic clock switch.
// (RQ23) Mute stays active until enabled flags cleared and external request inactive.
// (RQ24) Fail when latched count below lower bound or running count above upper.
// (RQ25) Each flag has its own interrupt enable; request only when both set.
// (RQ26) Frame sync error flags sticky until software writes one.
package apem_pkg;
    localparam int NSER = 4;
    localparam logic [7:0] TX_STATUS_OFS = 8'h00;
    localparam logic [7:0] RX_STATUS_OFS = 8'h04;
    localparam logic [7:0] TX_IRQ_EN_OFS = 8'h08;
    localparam logic [7:0] RX_IRQ_EN_OFS = 8'h0c;
    localparam logic [7:0] MUTE_CTRL_OFS = 8'h10;
    localparam logic [7:0] TX_CLK_CHECK_OFS = 8'h14;
    localparam logic [7:0] RX_CLK_CHECK_OFS = 8'h18;
    localparam logic [7:0] SERIAL_CFG_OFS = 8'h1c;
    localparam int CFG_DIR_LSB = 0;
    localparam int CFG_EN_LSB = 4;
    localparam int CFG_BURST_LSB = 8;
    localparam int CFG_BMC_BIT = 10;
    localparam int CFG_SLOTS_LSB = 16;
    localparam int CFG_BITS_LSB = 24;
    localparam logic [31:0] CFG_MASK = 32'h1f3f07ff;
    localparam int MUTE_TXEN_LSB = 0;
    localparam int MUTE_RXEN_LSB = 4;
    localparam int MUTE_EXTEN_BIT = 8;
    localparam int MUTE_EXTPOL_BIT = 9;
    localparam int MUTE_LEVEL_BIT = 10;
    localparam int CHK_CNT_LSB = 24;
    localparam logic [3:0] FLAGS_RST = 4'h4;
    localparam logic [10:0] MUTE_CTRL_RST = 11'h000;
    localparam logic [18:0] CHK_RST = 19'h0ff00;
    localparam logic MUTE_OUT_RST = 1'b1;
    localparam logic [4:0] WINDOW_LAST = 5'h1f;
    localparam logic [3:0] BMC_ZEROS = 4'hc;
    localparam logic [2:0] BMC_BITS = 3'h4;

    typedef struct packed {
        logic dma;
        logic clk;
        logic sync;
        logic xrun;
    } apem_flags_type;

    typedef struct packed {
        logic [2:0] ps;
        logic [7:0] hi;
        logic [7:0] lo;
    } apem_chk_type;

    typedef enum logic [1:0] {
        APEM_IDLE = 2'b01,
        APEM_RUN = 2'b10
    } apem_frame_state_type;
endpackage

/* hdl/apem_top.sv */
module apem_top (
    // System
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Serial pins
    input wire logic TX_MASTER_CLOCK_IN,
    input wire logic RX_MASTER_CLOCK_IN,
    input wire logic TX_BIT_CLOCK_IN,
    input wire logic TX_FRAME_SYNC_IN,
    input wire logic RX_BIT_CLOCK_IN,
    input wire logic RX_FRAME_SYNC_IN,
    input wire logic EXT_MUTE_REQUEST_IN,
    // Serializer and data port events
    input wire logic TX_SLOT_XFER_IN,
    input wire logic RX_SLOT_XFER_IN,
    input wire logic DATA_WRITE_IN,
    input wire logic DATA_READ_IN,
    // Outputs
    output logic MUTE_OUTPUT_OUT,
    output logic TX_IRQ_OUT,
    output logic RX_IRQ_OUT,
    output logic TX_FILL_ACTIVE_OUT,
    output logic TX_FILL_DATA_OUT
);
    localparam logic [3:0] SEL_CFG = 4'h7;
    localparam logic [3:0] SEL_MUTE = 4'h4;
    localparam logic [3:0] SEL_NONE = 4'h8;

    function automatic logic [3:0] reg_sel(input logic [7:0] a);
        logic [3:0] r;
        r = SEL_NONE;
        if (a == apem_pkg::TX_STATUS_OFS)
            r = 4'h0;
        else if (a == apem_pkg::RX_STATUS_OFS)
            r = 4'h1;
        else if (a == apem_pkg::TX_IRQ_EN_OFS)
            r = 4'h2;
        else if (a == apem_pkg::RX_IRQ_EN_OFS)
            r = 4'h3;
        else if (a == apem_pkg::MUTE_CTRL_OFS)
            r = SEL_MUTE;
        else if (a == apem_pkg::TX_CLK_CHECK_OFS)
            r = 4'h5;
        else if (a == apem_pkg::RX_CLK_CHECK_OFS)
            r = 4'h6;
        else if (a == apem_pkg::SERIAL_CFG_OFS)
            r = SEL_CFG;
        return r;
    endfunction

    function automatic logic [2:0] pop4(input logic [3:0] m);
        return 3'({2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]});
    endfunction

    // One-hot pick of the n-th set bit, counted from bit 0
    function automatic logic [3:0] nth4(input logic [3:0] m, input logic [2:0] n);
        logic [3:0] r;
        logic [2:0] k;
        r = 4'h0;
        k = 3'h0;
        for (int i = 0; i < apem_pkg::NSER; i++)
        begin
            if (m[i])
            begin
                if (k == n)
                    r[i] = 1'b1;
                k = k + 3'h1;
            end
        end
        return r;
    endfunction

    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (RESET_IN);

    // Pin synchronisers; stage three only feeds edge detection
    logic [6:0] pin_raw;
    logic [6:0] pin_s1_q;
    logic [6:0] pin_s2_q;
    logic [6:0] pin_s3_q;
    assign pin_raw = {EXT_MUTE_REQUEST_IN, RX_FRAME_SYNC_IN, RX_BIT_CLOCK_IN,
        TX_FRAME_SYNC_IN, TX_BIT_CLOCK_IN, RX_MASTER_CLOCK_IN, TX_MASTER_CLOCK_IN};

    always_ff @(posedge CLOCK_IN)
    begin
        if (RESET_IN)
        begin
            pin_s1_q <= 7'h00;
            pin_s2_q <= 7'h00;
            pin_s3_q <= 7'h00;
        end
        else
        begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // APB: one wait state so read data leaves a flip-flop
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic setup_acc;
    logic wr_commit;
    logic [3:0] sel;
    logic [31:0] rd_val;
    assign sel = reg_sel(PADDR_IN);
    assign setup_acc = PSEL_IN & PENABLE_IN & ~pready_q;
    assign wr_commit = PSEL_IN & PENABLE_IN & pready_q & PWRITE_IN;

    apem_pkg::apem_flags_type flags_q [2];
    logic [3:0] irq_en_q [2];
    apem_pkg::apem_chk_type chk_q [2];
    logic [7:0] cnt_q [2];
    logic [10:0] mute_ctl_q;
    logic [31:0] cfg_q;
    logic irq_q [2];

    always_comb
    begin
        rd_val = 32'h0;
        if (sel == SEL_MUTE)
            rd_val = {21'h0, mute_ctl_q};
        else if (sel == SEL_CFG)
            rd_val = cfg_q;
        else if (sel == 4'h0 || sel == 4'h1)
            rd_val = {28'h0, flags_q[sel[0]]};
        else if (sel == 4'h2 || sel == 4'h3)
            rd_val = {28'h0, irq_en_q[sel[0]]};
        else if (sel == 4'h5 || sel == 4'h6)
            rd_val = {cnt_q[~sel[0]], 5'h0, chk_q[~sel[0]]}; // RQ1
    end

    always_ff @(posedge CLOCK_IN)
    begin
        if (RESET_IN)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else
        begin
            pready_q <= setup_acc;
            if (setup_acc)
            begin
                pslverr_q <= (sel == SEL_NONE);
                prdata_q <= PWRITE_IN ? 32'h0 : rd_val;
            end
        end
    end

    always_ff @(posedge CLOCK_IN)
    begin
        if (RESET_IN)
        begin
            mute_ctl_q <= apem_pkg::MUTE_CTRL_RST;
            cfg_q <= 32'h0;
        end
        else if (wr_commit)
        begin
            if (sel == SEL_MUTE)
                mute_ctl_q <= PWDATA_IN[10:0];
            else if (sel == SEL_CFG)
                cfg_q <= PWDATA_IN & apem_pkg::CFG_MASK;
        end
    end

    // Serializer membership: direction bit high means transmitter
    logic [3:0] member [2];
    logic [3:0] fresh_q;
    logic [3:0] hit [2];
    logic xfer [2];
    logic port_acc [2];
    logic xrun_set [2];
    logic dma_set [2];
    logic sync_set [2];
    logic clk_set [2];
    logic bedge [2];
    logic bmc_mode;
    assign bmc_mode = cfg_q[apem_pkg::CFG_BMC_BIT];
    assign member[0] = cfg_q[apem_pkg::CFG_EN_LSB +: 4] & cfg_q[apem_pkg::CFG_DIR_LSB +: 4];
    assign member[1] = cfg_q[apem_pkg::CFG_EN_LSB +: 4] & ~cfg_q[apem_pkg::CFG_DIR_LSB +: 4];
    assign xfer[0] = TX_SLOT_XFER_IN;
    assign xfer[1] = RX_SLOT_XFER_IN;
    assign port_acc[0] = DATA_WRITE_IN;
    assign port_acc[1] = DATA_READ_IN;
    // One transfer strobe per slot, so each slot is checked once
    assign xrun_set[0] = xfer[0] & |(member[0] & ~fresh_q); // RQ11 RQ12
    assign xrun_set[1] = xfer[1] & |(member[1] & fresh_q); // RQ15 RQ16

    // Write during a transmit transfer counts as fresh; set beats clear
    always_ff @(posedge CLOCK_IN)
    begin
        if (RESET_IN)
            fresh_q <= 4'h0;
        else
            fresh_q <= ((((fresh_q & ~(xfer[0] ? member[0] : 4'h0)) | hit[0]) & ~hit[1])
                | (xfer[1] ? member[1] : 4'h0)) & (member[0] | member[1]); // RQ15
    end

    genvar s;
    generate
        for (s = 0; s < 2; s++)
        begin : g_sec
            // Data port word count per DMA event
            logic [2:0] wcnt_q;
            assign dma_set[s] = port_acc[s] & (wcnt_q >= pop4(member[s])); // RQ17 RQ18
            assign hit[s] = (port_acc[s] & ~dma_set[s]) ? nth4(member[s], wcnt_q) : 4'h0;

            always_ff @(posedge CLOCK_IN)
            begin
                if (RESET_IN)
                    wcnt_q <= 3'h0;
                else if (xfer[s])
                    wcnt_q <= 3'h0;
                else if (port_acc[s] & ~dma_set[s])
                    wcnt_q <= wcnt_q + 3'h1;
            end

            // Clock check: count prescaled system ticks over 32 master edges
            logic [7:0] pre_q;
            logic [7:0] mask;
            logic [4:0] edges_q;
            logic [8:0] run_q;
            logic valid_q;
            logic medge;
            logic latch;
            logic [7:0] run_sat;
            assign medge = pin_s2_q[s] & ~pin_s3_q[s];
            assign latch = medge & (edges_q == apem_pkg::WINDOW_LAST); // RQ1
            assign mask = 8'((9'h001 << chk_q[s].ps) - 9'h001);
            assign run_sat = run_q[8] ? 8'hff : run_q[7:0];
            // Upper bound uses the running count so a stopped clock still fails
            assign clk_set[s] = ~valid_q | (latch & (run_sat < chk_q[s].lo))
                | (run_q > {1'b0, chk_q[s].hi}); // RQ2 RQ20 RQ24

            always_ff @(posedge CLOCK_IN)
            begin
                if (RESET_IN)
                begin
                    pre_q <= 8'h00;
                    edges_q <= 5'h00;
                    run_q <= 9'h000;
                    valid_q <= 1'b0;
                    cnt_q[s] <= 8'h00;
                end
                else
                begin
                    pre_q <= pre_q + 8'h01;
                    if (medge)
                        edges_q <= edges_q + 5'h01;
                    if (latch)
                    begin
                        run_q <= 9'h000;
                        cnt_q[s] <= run_sat; // RQ1
                        valid_q <= 1'b1; // RQ20
                    end
                    else if (((pre_q & mask) == mask) && !run_q[8])
                        run_q <= run_q + 9'h001;
                end
            end

            // Frame sync checker, in sync-to-sync period terms
            apem_pkg::apem_frame_state_type st_q;
            logic [11:0] fcnt_q;
            logic [11:0] last;
            logic fs_prev_q;
            logic fs;
            logic sync_ev;
            logic at_end;
            logic [5:0] slots_m1;
            logic [4:0] bits_m1;
            assign slots_m1 = cfg_q[apem_pkg::CFG_SLOTS_LSB +: 6];
            assign bits_m1 = cfg_q[apem_pkg::CFG_BITS_LSB +: 5];
            assign bedge[s] = pin_s2_q[2 + 2 * s] & ~pin_s3_q[2 + 2 * s];
            assign fs = pin_s2_q[3 + 2 * s];
            assign sync_ev = bedge[s] & fs & ~fs_prev_q;
            assign last = cfg_q[apem_pkg::CFG_BURST_LSB + s] ? {7'h0, bits_m1} // RQ5
                : 12'(({6'h0, slots_m1} + 12'h1) * ({7'h0, bits_m1} + 12'h1) - 12'h1); // RQ6
            assign at_end = (fcnt_q == last);
            // Delay shifts data, not the sync period, so delay overlap is never early
            assign sync_set[s] = bedge[s] & (st_q == apem_pkg::APEM_RUN)
                & (sync_ev ? ~at_end : at_end); // RQ7 RQ8 RQ9 RQ10

            always_ff @(posedge CLOCK_IN)
            begin
                if (RESET_IN)
                begin
                    st_q <= apem_pkg::APEM_IDLE;
                    fcnt_q <= 12'h000;
                    fs_prev_q <= 1'b0;
                end
                else
                begin
                    if (bedge[s])
                        fs_prev_q <= fs;
                    case (st_q)
                        apem_pkg::APEM_IDLE:
                        begin
                            if (sync_ev)
                            begin
                                st_q <= apem_pkg::APEM_RUN; // RQ9
                                fcnt_q <= 12'h000;
                            end
                        end
                        apem_pkg::APEM_RUN:
                        begin
                            if (bedge[s] && at_end)
                            begin
                                if (sync_ev)
                                    fcnt_q <= 12'h000;
                                else
                                    st_q <= apem_pkg::APEM_IDLE; // RQ9
                            end
                            else if (bedge[s])
                                fcnt_q <= fcnt_q + 12'h001; // RQ8
                        end
                        default:
                            st_q <= apem_pkg::APEM_IDLE;
                    endcase
                end
            end

            // Status, enables, bounds
            logic [3:0] clr;
            logic [3:0] set_v;
            assign clr = (wr_commit && sel == 4'(s)) ? PWDATA_IN[3:0] : 4'h0;
            assign set_v = {dma_set[s], clk_set[s], sync_set[s], xrun_set[s]};

            always_ff @(posedge CLOCK_IN)
            begin
                if (RESET_IN)
                begin
                    flags_q[s] <= apem_pkg::FLAGS_RST;
                    irq_en_q[s] <= 4'h0;
                    chk_q[s] <= apem_pkg::CHK_RST;
                    irq_q[s] <= 1'b0;
                end
                else
                begin
                    flags_q[s] <= (flags_q[s] & ~clr) | set_v; // RQ12 RQ16 RQ26
                    irq_q[s] <= |(flags_q[s] & irq_en_q[s]); // RQ4 RQ25
                    if (wr_commit && sel == 4'(2 + s))
                        irq_en_q[s] <= PWDATA_IN[3:0];
                    if (wr_commit && sel == 4'(5 + s))
                        chk_q[s] <= PWDATA_IN[18:0];
                end
            end

            sticky_flag_a: assert property ( // RQ12
                (flags_q[s] != 4'h0) && !(wr_commit && sel == 4'(s))
                |=> ((flags_q[s] & $past(flags_q[s])) == $past(flags_q[s])))
                else $error("Status flag dropped without a clear");
            irq_follow_a: assert property ( // RQ25
                ##1 (irq_q[s] == |($past(flags_q[s]) & $past(irq_en_q[s]))))
                else $error("Interrupt does not follow flag and enable");
            dma_flag_a: assert property ( // RQ17
                port_acc[s] && wcnt_q >= pop4(member[s]) |=> flags_q[s].dma)
                else $error("Excess data port word not flagged");
            early_sync_a: assert property ( // RQ8
                st_q == apem_pkg::APEM_RUN && sync_ev && !at_end
                |=> flags_q[s].sync && st_q == apem_pkg::APEM_RUN && fcnt_q == $past(fcnt_q) + 12'h001)
                else $error("Early sync not flagged or frame not completed");
            clk_upper_a: assert property ( // RQ24
                run_q > {1'b0, chk_q[s].hi} |=> flags_q[s].clk)
                else $error("Running count over bound not flagged");
            clk_latch_a: assert property ( // RQ1
                latch |=> cnt_q[s] == $past(run_sat) && run_q == 9'h000 && valid_q)
                else $error("Window count not latched");
        end
    endgenerate

    // Underrun fill: biphase zero pair, or zeros held while flagged
    logic fill_active_q;
    logic fill_data_q;
    logic [3:0] bmc_sh_q;
    logic [2:0] bmc_left_q;

    always_ff @(posedge CLOCK_IN)
    begin
        if (RESET_IN)
        begin
            fill_active_q <= 1'b0;
            fill_data_q <= 1'b0;
            bmc_sh_q <= 4'h0;
            bmc_left_q <= 3'h0;
        end
        else if (xrun_set[0] && bmc_mode)
        begin
            bmc_sh_q <= apem_pkg::BMC_ZEROS; // RQ13
            bmc_left_q <= apem_pkg::BMC_BITS;
            fill_active_q <= 1'b1;
            fill_data_q <= apem_pkg::BMC_ZEROS[3];
        end
        else if (bmc_left_q != 3'h0)
        begin
            fill_active_q <= 1'b1;
            fill_data_q <= bmc_sh_q[3];
            if (bedge[0])
            begin
                bmc_sh_q <= {bmc_sh_q[2:0], 1'b0};
                bmc_left_q <= bmc_left_q - 3'h1; // RQ13
            end
        end
        else
        begin
            // Clearing the underrun flag or a reset ends this; the converters see silence meanwhile
            fill_active_q <= (xrun_set[0] | flags_q[0].xrun) & ~bmc_mode; // RQ14
            fill_data_q <= 1'b0;
        end
    end

    // Mute
    logic mute_q;
    logic mute_src;
    logic mute_level;
    assign mute_level = mute_ctl_q[apem_pkg::MUTE_LEVEL_BIT];
    assign mute_src = |(flags_q[0] & mute_ctl_q[apem_pkg::MUTE_TXEN_LSB +: 4])
        | |(flags_q[1] & mute_ctl_q[apem_pkg::MUTE_RXEN_LSB +: 4])
        | (mute_ctl_q[apem_pkg::MUTE_EXTEN_BIT]
        & (pin_s2_q[6] == mute_ctl_q[apem_pkg::MUTE_EXTPOL_BIT]));

    always_ff @(posedge CLOCK_IN)
    begin
        if (RESET_IN)
            mute_q <= apem_pkg::MUTE_OUT_RST;
        else
            mute_q <= mute_src ? mute_level : ~mute_level; // RQ3 RQ23
    end

    mute_follow_a: assert property ( // RQ23
        mute_src |=> mute_q == $past(mute_level))
        else $error("Mute not at active level");
    underrun_flag_a: assert property ( // RQ11
        xfer[0] && |(member[0] & ~fresh_q) |=> flags_q[0].xrun)
        else $error("Underrun not flagged");
    overrun_flag_a: assert property ( // RQ15
        xfer[1] && |(member[1] & fresh_q) |=> flags_q[1].xrun && ((fresh_q & member[1]) == member[1]))
        else $error("Overrun not flagged or buffer not refilled");
    bmc_pair_a: assert property ( // RQ13
        xrun_set[0] && bmc_mode |=> fill_active_q && fill_data_q && bmc_left_q == 3'h4)
        else $error("Biphase zero pair not started");

    assign PRDATA_OUT = prdata_q;
    assign PREADY_OUT = pready_q;
    assign PSLVERR_OUT = pslverr_q;
    assign MUTE_OUTPUT_OUT = mute_q;
    assign TX_IRQ_OUT = irq_q[0];
    assign RX_IRQ_OUT = irq_q[1];
    assign TX_FILL_ACTIVE_OUT = fill_active_q;
    assign TX_FILL_DATA_OUT = fill_data_q;
endmodule

/* tb/apem_far_end.sv */
module apem_far_end #(
    parameter int FRAME_BITS = 8
) (
    // Controls
    input wire logic run_in,
    input wire logic [1:0] fault_in,
    // Pins
    output logic mclk_out,
    output logic bclk_out,
    output logic fsync_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] f;
    initial
    begin
        mclk_out = 1'b0;
        forever #20 mclk_out = ~mclk_out;
    end
    // Frames run back to back while run_in is high; 1 adds an early sync, 2 drops one
    initial
    begin
        bclk_out = 1'b0;
        fsync_out = 1'b0;
        forever
        begin
            wait (run_in);
            f = fault_in;
            for (int i = 0; i < FRAME_BITS; i++)
            begin
                fsync_out = (i == 0 && f != 2'd2) || (i == 3 && f == 2'd1);
                #80 bclk_out = 1'b1;
                #80 bclk_out = 1'b0;
            end
        end
    end
endmodule

/* tb/apem_top_tb.sv */
module apem_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic r;
    } apem_row_type;
    localparam logic [7:0] TXS = apem_pkg::TX_STATUS_OFS;
    localparam logic [7:0] RXS = apem_pkg::RX_STATUS_OFS;
    logic clk, rst, psel, pen, pwr, ext, run, err;
    logic pready, pslverr, mute, txirq, rxirq, fill, fdat, mclk, bclk, fs;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] ev;
    logic [1:0] fault;
    int miscompares, samples_checked;
    apem_row_type rows [6] = '{'{apem_pkg::MUTE_CTRL_OFS, '1, 32'h7ff, 0},
        '{apem_pkg::MUTE_CTRL_OFS, 0, 0, 0}, '{apem_pkg::TX_IRQ_EN_OFS, '1, 32'hf, 0},
        '{apem_pkg::RX_IRQ_EN_OFS, '1, 32'hf, 0}, '{8'h20, 1, 0, 1},
        '{apem_pkg::SERIAL_CFG_OFS, '1, apem_pkg::CFG_MASK, 0}};
    logic [31:0] bnd [2] = '{32'hffc8, 32'h6400};
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    apem_far_end far_u (.run_in(run), .fault_in(fault), .mclk_out(mclk), .bclk_out(bclk),
        .fsync_out(fs));
    apem_top dut_u (
        .CLOCK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .TX_MASTER_CLOCK_IN(mclk), .RX_MASTER_CLOCK_IN(mclk),
        .TX_BIT_CLOCK_IN(bclk), .TX_FRAME_SYNC_IN(fs), .RX_BIT_CLOCK_IN(bclk),
        .RX_FRAME_SYNC_IN(fs), .EXT_MUTE_REQUEST_IN(ext), .TX_SLOT_XFER_IN(ev[0]),
        .RX_SLOT_XFER_IN(ev[1]), .DATA_WRITE_IN(ev[2]), .DATA_READ_IN(ev[3]),
        .MUTE_OUTPUT_OUT(mute), .TX_IRQ_OUT(txirq), .RX_IRQ_OUT(rxirq),
        .TX_FILL_ACTIVE_OUT(fill), .TX_FILL_DATA_OUT(fdat));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Idle cycle after each transfer so no signal is assigned twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
        cyc(1);
        pen <= 1'b1;
        i = 0;
        do
        begin
            cyc(1);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        q = prdata;
        err = pslverr;
        {psel, pen} <= 2'b00;
        cyc(1);
        if (i >= 20)
        begin
            miscompares++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic pulse(input int k, input int n);
        repeat (n)
        begin
            ev[k] <= 1'b1;
            cyc(1);
            ev[k] <= 1'b0;
            cyc(1);
        end
    endtask
    initial
    begin
        {rst, psel, pen, pwr, ext, run, err, paddr, pwdata, ev, fault} = {1'b1, 52'h0};
        cyc(16);
        rst <= 1'b0;
        cyc(1);
        chk(32'({mute, txirq, rxirq, fill}), 32'h8);
        rd(TXS, 32'(apem_pkg::FLAGS_RST));
        rd(RXS, 32'(apem_pkg::FLAGS_RST));
        apb(1'b0, apem_pkg::TX_CLK_CHECK_OFS, 32'h0);
        chk(32'(q[18:0]), 32'(apem_pkg::CHK_RST));
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            chk(32'(err), 32'(rows[i].r));
            rd(rows[i].a, rows[i].e);
        end
        wr(apem_pkg::SERIAL_CFG_OFS, 32'h030100f3);
        chk(32'(txirq), 32'h1);
        wr(apem_pkg::MUTE_CTRL_OFS, 32'h4);
        cyc(3);
        chk(32'(mute), 32'h0);
        cyc(400);
        wr(TXS, 32'h4);
        wr(RXS, 32'h4);
        cyc(3);
        chk(32'({txirq, rxirq, mute}), 32'h1);
        wr(apem_pkg::MUTE_CTRL_OFS, 32'h300);
        ext <= 1'b1;
        cyc(6);
        chk(32'(mute), 32'h0);
        ext <= 1'b0;
        cyc(6);
        chk(32'(mute), 32'h1);
        apb(1'b0, apem_pkg::TX_CLK_CHECK_OFS, 32'h0);
        chk(32'(q[31:24] inside {[8'h9e:8'ha2]}), 32'h1);
        foreach (bnd[i])
        begin
            wr(apem_pkg::RX_CLK_CHECK_OFS, bnd[i]);
            wr(RXS, 32'h4);
            cyc(400);
            rd(RXS, 32'h4);
        end
        wr(apem_pkg::RX_CLK_CHECK_OFS, 32'hff00);
        cyc(400);
        wr(RXS, 32'hf);
        wr(apem_pkg::MUTE_CTRL_OFS, 32'h1);
        pulse(0, 1);
        cyc(3);
        chk(32'({mute, txirq, fill, fdat}), 32'h6);
        rd(TXS, 32'h1);
        wr(TXS, 32'h1);
        cyc(3);
        chk(32'({mute, txirq}), 32'h2);
        // Two writes fill both transmitters, a third is one too many
        pulse(2, 2);
        pulse(0, 1);
        pulse(2, 3);
        cyc(3);
        rd(TXS, 32'h8);
        wr(TXS, 32'h8);
        pulse(1, 1);
        pulse(3, 3);
        pulse(1, 2);
        pulse(3, 2);
        pulse(1, 1);
        cyc(3);
        rd(RXS, 32'h9);
        chk(32'(rxirq), 32'h1);
        wr(RXS, 32'hf);
        run <= 1'b1;
        cyc(500);
        for (int i = 0; i < 4; i++)
        begin
            wr(TXS, 32'h2);
            wr(RXS, 32'h2);
            fault <= 2'(i);
            cyc(160);
            fault <= 2'd0;
            cyc(400);
            rd(TXS, (i % 3 == 0) ? 32'h0 : 32'h2);
            rd(RXS, (i % 3 == 0) ? 32'h0 : 32'h2);
        end
        // Burst frames are half the sync period, so every frame ends in a gap
        wr(apem_pkg::TX_IRQ_EN_OFS, 32'hd);
        wr(apem_pkg::SERIAL_CFG_OFS, 32'h030103f3);
        wr(TXS, 32'h2);
        cyc(400);
        rd(TXS, 32'h2);
        chk(32'(txirq), 32'h0);
        wr(apem_pkg::SERIAL_CFG_OFS, 32'h030104f3);
        pulse(0, 2);
        cyc(3);
        chk(32'({fill, fdat}), 32'h3);
        cyc(200);
        chk(32'(fill), 32'h0);
        // Reset in mid-run with the link still clocking
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        chk(32'({mute, txirq, rxirq, fill}), 32'h8);
        rd(TXS, 32'(apem_pkg::FLAGS_RST));
        report_and_stop();
    end
endmodule
